/* hw/platform_power_control_arbiter.v */
/*
 * Platform power control arbiter: takes power requests from the front
 * panel button, watchdog expiry, commands, AC restore retention, the
 * chipset sleep line and wake-on-LAN, serialises them, sequences host
 * power, and applies sleep-state policy to watchdog, fans and buttons.
 * Assumes pin inputs are asynchronous (synchronised here) and that the
 * command and watchdog ports come from logic on ref_clk.
 */
`timescale 1ns/1ps
`include "power_ctl_defs.vh"
module platform_power_control_arbiter #(
    parameter OFF_HOLD_CYCLES  = `OFF_HOLD_CYC,
    parameter BOOT_WAIT_CYCLES = `BOOT_WAIT_CYC
) (
    // Clock and reset
    input  wire       ref_clk,
    input  wire       rst,
    // Pins from the platform
    input  wire       button_n,
    input  wire       ac_restored,
    input  wire       chipset_on,
    input  wire       wake_lan,
    input  wire       host_pwr_good,
    // Same-domain requests
    input  wire       wdog_expire,
    input  wire       wdog_cycle,
    input  wire [1:0] cmd_action,
    input  wire       cmd_valid,
    input  wire       retain_enable,
    // Sleep state notices from the BIOS SMI handler, and the S1 fan choice (fan_rec_fixed)
    input  wire       s1_enter,
    input  wire       s1_exit,
    input  wire       s5_enter,
    input  wire       fan_rec_fixed,
    // Outputs
    output reg        host_pwr_en,
    output reg        boot_start,
    output reg        busy,
    output reg        wdog_run,
    output reg  [1:0] fan_mode,
    output reg        button_protect,
    output reg  [1:0] sleep_state
);
    localparam ST_IDLE  = 4'b0001;
    localparam ST_OFF   = 4'b0010;
    localparam ST_ON    = 4'b0100;
    localparam ST_BOOT  = 4'b1000;

    wire [4:0] pin_sync;
    sync_pair #(.WIDTH(5)) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .din     ({~button_n, ac_restored, chipset_on, wake_lan, host_pwr_good}),
        .dout    (pin_sync)
    );
    wire button_s = pin_sync[4];
    wire ac_s     = pin_sync[3];
    wire chip_s   = pin_sync[2];
    wire wake_s   = pin_sync[1];
    wire pgood_s  = pin_sync[0];

    reg        button_d;
    reg        ac_d;
    reg        chip_d;
    reg        wake_d;
    reg [`SRC_COUNT-1:0] pend;
    reg [1:0]  pend_act [0:`SRC_COUNT-1];
    reg [3:0]  state;
    reg [1:0]  cur_act;
    reg [31:0] timer;
    reg        pwr_d;

    // Edge events from each pin source
    wire       button_rise = button_s & ~button_d;
    wire       ac_rise     = ac_s & ~ac_d;
    wire       chip_edge   = chip_s ^ chip_d;
    wire       wake_rise   = wake_s & ~wake_d;

    reg [`SRC_COUNT-1:0] ev;
    reg [1:0]  ev_act [0:`SRC_COUNT-1];
    always @*
    begin
        ev[`SRC_BUTTON]      = button_rise;
        ev_act[`SRC_BUTTON]  = host_pwr_en ? `ACT_OFF : `ACT_ON;
        ev[`SRC_WDOG]        = wdog_expire & wdog_run;
        ev_act[`SRC_WDOG]    = wdog_cycle ? `ACT_CYCLE : `ACT_OFF;
        ev[`SRC_CMD]         = cmd_valid & (cmd_action != `ACT_NONE);
        ev_act[`SRC_CMD]     = cmd_action;
        ev[`SRC_RESTORE]     = ac_rise & retain_enable;
        ev_act[`SRC_RESTORE] = `ACT_ON;
        ev[`SRC_CHIPSET]     = chip_edge;
        ev_act[`SRC_CHIPSET] = chip_s ? `ACT_ON : `ACT_OFF;
        ev[`SRC_WAKE]        = wake_rise;
        ev_act[`SRC_WAKE]    = `ACT_ON;
    end

    // Lowest index wins; the rest wait in their pending slot
    reg [`SRC_COUNT-1:0] grant;
    integer k;
    always @*
    begin
        grant = {`SRC_COUNT{1'b0}};
        for (k = `SRC_COUNT - 1; k >= 0; k = k - 1)
        begin
            if (pend[k])
                grant = ({{(`SRC_COUNT-1){1'b0}}, 1'b1} << k);
        end
    end

    reg [1:0] grant_act;
    always @*
    begin
        grant_act = `ACT_NONE;
        for (k = 0; k < `SRC_COUNT; k = k + 1)
        begin
            if (grant[k])
                grant_act = pend_act[k];
        end
    end

    // Pending slots: a new event wins over the clear of its own grant
    genvar g;
    generate
        for (g = 0; g < `SRC_COUNT; g = g + 1)
        begin : g_slot
            always @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                begin
                    pend[g]     <= 1'b0;
                    pend_act[g] <= `ACT_NONE;
                end
                else if (ev[g])
                begin
                    pend[g]     <= 1'b1;
                    pend_act[g] <= ev_act[g];
                end
                else if (state == ST_IDLE && grant[g])
                    pend[g] <= 1'b0;
            end
        end
    endgenerate

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            button_d    <= 1'b0;
            ac_d        <= 1'b0;
            chip_d      <= 1'b0;
            wake_d      <= 1'b0;
            state       <= ST_IDLE;
            cur_act     <= `ACT_NONE;
            timer       <= 32'h0;
            host_pwr_en <= 1'b0;
            boot_start  <= 1'b0;
            busy        <= 1'b0;
        end
        else
        begin
            button_d   <= button_s;
            ac_d       <= ac_s;
            chip_d     <= chip_s;
            wake_d     <= wake_s;
            boot_start <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    busy <= 1'b0;
                    if (grant_act == `ACT_ON && !host_pwr_en)
                    begin
                        busy    <= 1'b1;
                        cur_act <= `ACT_ON;
                        state   <= ST_ON;
                    end
                    else if ((grant_act == `ACT_OFF && host_pwr_en)
                             || grant_act == `ACT_CYCLE)
                    begin
                        busy    <= 1'b1;
                        cur_act <= grant_act;
                        timer   <= 32'h0;
                        state   <= ST_OFF;
                    end
                end
                ST_OFF:
                begin
                    host_pwr_en <= 1'b0;
                    // Hold off long enough for rails to drain before a restart that follows an off or cycle action
                    if (timer >= OFF_HOLD_CYCLES - 1)
                        state <= (cur_act == `ACT_CYCLE) ? ST_ON : ST_IDLE;
                    else
                        timer <= timer + 32'h1;
                end
                ST_ON:
                begin
                    host_pwr_en <= 1'b1;
                    timer       <= 32'h0;
                    state       <= ST_BOOT;
                end
                ST_BOOT:
                begin
                    // Every power-up, S5 included, waits for good power then
                    // starts the normal boot, or drops power after BOOT_WAIT_CYCLES without it; no short path exists
                    if (pgood_s)
                    begin
                        boot_start <= 1'b1;
                        state      <= ST_IDLE;
                    end
                    else if (timer >= BOOT_WAIT_CYCLES - 1)
                    begin
                        host_pwr_en <= 1'b0;
                        state       <= ST_IDLE;
                    end
                    else
                        timer <= timer + 32'h1;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Sleep state tracking and policy outputs
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sleep_state    <= `SLP_S5;
            pwr_d          <= 1'b0;
            wdog_run       <= 1'b0;
            fan_mode       <= `FAN_STOP;
            button_protect <= 1'b0;
        end
        else
        begin
            pwr_d <= host_pwr_en;
            if (!host_pwr_en || s5_enter)
                sleep_state <= `SLP_S5;
            else if (s1_enter)
                sleep_state <= `SLP_S1;
            else if (sleep_state == `SLP_S1 && s1_exit)
                sleep_state <= `SLP_S0;
            // Only a fresh power-up or an s1_enter notice leaves S5, so an S5 notice holds until the next power-up or S1 is entered
            else if (sleep_state == `SLP_S5 && host_pwr_en && !pwr_d)
                sleep_state <= `SLP_S0;
            case (sleep_state)
                `SLP_S0:
                begin
                    wdog_run       <= 1'b1;
                    fan_mode       <= `FAN_NORMAL;
                    button_protect <= 1'b1;
                end
                `SLP_S1:
                begin
                    wdog_run       <= 1'b0;
                    fan_mode       <= fan_rec_fixed ? `FAN_FIXED : `FAN_BASIC;
                    button_protect <= 1'b0;
                end
                default:
                begin
                    wdog_run       <= 1'b0;
                    fan_mode       <= `FAN_STOP;
                    button_protect <= 1'b0;
                end
            endcase
        end
    end
endmodule

/* hw/power_ctl_defs.vh */
/*
 * Constants for the platform power control arbiter: request encodings,
 * sleep state codes, fan modes and sequencing times.
 * Assumes a 125 MHz ref_clk; included by bare name.
 */
`ifndef POWER_CTL_DEFS_VH
`define POWER_CTL_DEFS_VH

// Action codes
`define ACT_NONE        2'h0
`define ACT_ON          2'h1
`define ACT_OFF         2'h2
`define ACT_CYCLE       2'h3

// Host sleep state codes
`define SLP_S0          2'h0
`define SLP_S1          2'h1
`define SLP_S5          2'h2

// Fan mode codes
`define FAN_STOP        2'h0
`define FAN_NORMAL      2'h1
`define FAN_FIXED       2'h2
`define FAN_BASIC       2'h3

// Source indices in the request vector
`define SRC_BUTTON      0
`define SRC_WDOG        1
`define SRC_CMD         2
`define SRC_RESTORE     3
`define SRC_CHIPSET     4
`define SRC_WAKE        5
`define SRC_COUNT       6

// Sequencing times in microseconds, at 125 cycles per microsecond
`define CLK_PER_US      125
`define OFF_HOLD_US     1000
`define OFF_HOLD_CYC    (`OFF_HOLD_US * `CLK_PER_US)
`define BOOT_WAIT_US    100
`define BOOT_WAIT_CYC   (`BOOT_WAIT_US * `CLK_PER_US)

`endif

/* hw/sync_pair.v */
/*
 * Two-flop synchroniser for a vector of asynchronous levels.
 * Assumes inputs are quasi-static levels; pulses shorter than one
 * ref_clk period may be missed.
 */
`timescale 1ns/1ps
module sync_pair #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             ref_clk,
    input  wire             rst,
    // Data
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] meta;

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            meta <= {WIDTH{1'b0}};
            dout <= {WIDTH{1'b0}};
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

/* sim/host_chipset_model.sv */
/* Host chipset and SMI handler model: power good, sleep line, S-state notices.
   Assumes the bench calls its tasks after a ref_clk edge. */
`timescale 1ns/1ps
module host_chipset_model #(
    parameter LED_HALF = 4
) (
    input  wire ref_clk,
    input  wire host_pwr_en,
    input  wire slow,
    output reg  host_pwr_good = 1'b0,
    output reg  chipset_on    = 1'b0,
    output reg  s1_enter      = 1'b0,
    output reg  s1_exit       = 1'b0,
    output reg  s5_enter      = 1'b0,
    output reg  power_led     = 1'b0
);
    int lag     = 0;
    int led_cnt = 0;
    reg in_s1   = 1'b0;
    // Slow mode outlasts the boot wait on purpose
    always @(posedge ref_clk)
    begin
        lag <= host_pwr_en ? lag + 1 : 0;
        host_pwr_good <= host_pwr_en && lag >= (slow ? 40 : 2);
    end
    // Platform logic owns the power LED; half period cut short to fit the run
    always @(posedge ref_clk)
    begin
        if (!host_pwr_en || s5_enter || s1_exit)
            in_s1 <= 1'b0;
        else if (s1_enter)
            in_s1 <= 1'b1;
        if (!in_s1)
        begin
            led_cnt   <= 0;
            power_led <= host_pwr_en;
        end
        else if (led_cnt == LED_HALF - 1)
        begin
            led_cnt   <= 0;
            power_led <= ~power_led;
        end
        else
            led_cnt <= led_cnt + 1;
    end
    task sleep_line(input logic v);
        @(posedge ref_clk) chipset_on <= v;
    endtask
    task smi(input logic [2:0] k);
    begin
        @(posedge ref_clk);
        s5_enter <= k[2];
        s1_exit  <= k[1];
        s1_enter <= k[0];
        @(posedge ref_clk);
        s5_enter <= 1'b0;
        s1_exit  <= 1'b0;
        s1_enter <= 1'b0;
    end
    endtask
endmodule

/* sim/power_ctl_assertions.sv */
/* Port checker for the power control arbiter.
   Assumes it is bound onto every arbiter instance. */
`timescale 1ns/1ps
`include "power_ctl_defs.vh"
module power_ctl_assertions (
    // Clock and reset
    input wire       ref_clk,
    input wire       rst,
    // Watched signals
    input wire       s1_exit,
    input wire       fan_rec_fixed,
    input wire       host_pwr_en,
    input wire       boot_start,
    input wire       busy,
    input wire       wdog_run,
    input wire [1:0] fan_mode,
    input wire       button_protect,
    input wire [1:0] sleep_state
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    a_wdog_held_s1: assert property (sleep_state == `SLP_S1 |=> !wdog_run)
        else $error("watchdog runs in S1");
    a_fans_stop_s5: assert property (sleep_state == `SLP_S5 |=> fan_mode == `FAN_STOP)
        else $error("fans not stopped in S5");
    a_fans_rec_s1: assert property (sleep_state == `SLP_S1 |=>
        fan_mode == ($past(fan_rec_fixed) ? `FAN_FIXED : `FAN_BASIC))
        else $error("S1 fan mode wrong");
    a_normal_s0: assert property (sleep_state == `SLP_S0 |=>
        fan_mode == `FAN_NORMAL && button_protect)
        else $error("S0 policy wrong");
    a_buttons_free: assert property (sleep_state != `SLP_S0 |=> !button_protect)
        else $error("buttons locked outside S0");
    a_s1_exit_only: assert property (sleep_state == `SLP_S1 && !s1_exit && host_pwr_en
        |=> sleep_state != `SLP_S0)
        else $error("left S1 without notice");
    a_boot_powered: assert property (boot_start |-> host_pwr_en && busy ##1 !boot_start)
        else $error("boot pulse wrong");
    a_on_serial: assert property ($rose(host_pwr_en) |-> busy && $past(busy))
        else $error("power on outside action");
    a_off_serial: assert property ($fell(host_pwr_en) |-> busy ##[0:2] sleep_state == `SLP_S5)
        else $error("power off outside action");
endmodule

bind platform_power_control_arbiter power_ctl_assertions i_power_ctl_assertions (
    .ref_clk, .rst, .s1_exit, .fan_rec_fixed, .host_pwr_en, .boot_start, .busy,
    .wdog_run, .fan_mode, .button_protect, .sleep_state);

/* sim/testbench.sv */
/* Self-checking bench for the power control arbiter.
   Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`include "power_ctl_defs.vh"
module testbench;
    reg        ref_clk = 1'b0;
    reg        rst = 1'b1;
    reg        button_n = 1'b1;
    reg        ac_restored = 1'b0;
    reg        wake_lan = 1'b0;
    reg        wdog_expire = 1'b0;
    reg        wdog_cycle = 1'b0;
    reg  [1:0] cmd_action = 2'h0;
    reg        cmd_valid = 1'b0;
    reg        retain_enable = 1'b0;
    reg        fan_rec_fixed = 1'b0;
    reg        slow = 1'b0;
    wire       host_pwr_good, chipset_on, s1_enter, s1_exit, s5_enter;
    wire       host_pwr_en, boot_start, busy, wdog_run, button_protect;
    wire [1:0] fan_mode, sleep_state;
    wire       power_led;
    reg        led_seen = 1'b0;
    int        num_errors = 0;
    int        checks_done = 0;
    int        boots = 0;
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
        if (boot_start === 1'b1) boots <= boots + 1;
    platform_power_control_arbiter #(.OFF_HOLD_CYCLES(8), .BOOT_WAIT_CYCLES(16))
        i_platform_power_control_arbiter (.ref_clk, .rst, .button_n, .ac_restored,
        .chipset_on, .wake_lan, .host_pwr_good, .wdog_expire, .wdog_cycle, .cmd_action,
        .cmd_valid, .retain_enable, .s1_enter, .s1_exit, .s5_enter, .fan_rec_fixed,
        .host_pwr_en, .boot_start, .busy, .wdog_run, .fan_mode, .button_protect, .sleep_state);
    host_chipset_model i_host_chipset_model (.ref_clk, .host_pwr_en, .slow,
        .host_pwr_good, .chipset_on, .s1_enter, .s1_exit, .s5_enter, .power_led);
    task test_done;
    begin
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask
    task chk(input logic [3:0] s, input logic [3:0] e);
    begin
        checks_done++;
        if (s !== e)
        begin
            num_errors++;
            $display("Error %0t: got %h expected %h", $time, s, e);
        end
    end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Idle with power at v; a hang ends the run
    task settle(input logic v);
        int i;
    begin
        cyc(6);
        for (i = 0; i < 500 && (busy !== 1'b0 || host_pwr_en !== v); i++)
            cyc(1);
        if (i == 500)
        begin
            num_errors++;
            test_done;
        end
        else
            chk(host_pwr_en, v);
    end
    endtask
    task req(input logic w, input logic c, input logic [1:0] a);
    begin
        @(posedge ref_clk);
        wdog_expire <= w;
        wdog_cycle  <= c;
        cmd_valid   <= (a != 2'h0);
        cmd_action  <= a;
        @(posedge ref_clk);
        wdog_expire <= 1'b0;
        cmd_valid   <= 1'b0;
    end
    endtask
    task press;
    begin
        @(posedge ref_clk) button_n <= 1'b0;
        cyc(5);
        button_n <= 1'b1;
    end
    endtask
    task t_command;
    begin
        chk({sleep_state, fan_mode}, {`SLP_S5, `FAN_STOP});
        req(0, 0, `ACT_ON);
        settle(1);
        cyc(2);
        chk({button_protect, wdog_run}, 2'h3);
        chk(fan_mode, `FAN_NORMAL);
        boots = 0;
        req(0, 0, `ACT_ON);
        settle(1);
        req(0, 0, `ACT_CYCLE);
        settle(1);
        chk(boots[1:0], 2'h1);
        req(0, 0, `ACT_OFF);
        settle(0);
        cyc(2);
        chk(fan_mode, `FAN_STOP);
        chk({sleep_state, button_protect}, 3'h4);
    end
    endtask
    task t_sources;
    begin
        press;
        settle(1);
        press;
        settle(0);
        req(1, 0, `ACT_NONE);
        settle(0);
        @(posedge ref_clk) ac_restored <= 1'b1;
        settle(0);
        @(posedge ref_clk) ac_restored <= 1'b0;
        retain_enable <= 1'b1;
        cyc(4);
        ac_restored <= 1'b1;
        settle(1);
        i_host_chipset_model.sleep_line(1);
        settle(1);
        i_host_chipset_model.sleep_line(0);
        settle(0);
        @(posedge ref_clk) wake_lan <= 1'b1;
        settle(1);
        boots = 0;
        req(1, 1, `ACT_NONE);
        settle(1);
        chk(boots[1:0], 2'h1);
        req(1, 0, `ACT_ON);
        settle(1);
        chk(boots[1:0], 2'h2);
    end
    endtask
    task t_sleep;
    begin
        i_host_chipset_model.smi(3'h1);
        cyc(3);
        chk({sleep_state, button_protect, wdog_run}, {`SLP_S1, 2'h0});
        chk(fan_mode, `FAN_BASIC);
        led_seen = power_led;
        cyc(4);
        chk(power_led, !led_seen);
        @(posedge ref_clk) fan_rec_fixed <= 1'b1;
        req(1, 0, `ACT_NONE);
        settle(1);
        chk(fan_mode, `FAN_FIXED);
        chk(sleep_state, `SLP_S1);
        i_host_chipset_model.smi(3'h2);
        cyc(3);
        chk(sleep_state, `SLP_S0);
        i_host_chipset_model.smi(3'h4);
        cyc(3);
        chk({sleep_state, fan_mode}, {`SLP_S5, `FAN_STOP});
        chk({button_protect, wdog_run}, 2'h0);
        cyc(3);
        chk(sleep_state, `SLP_S5);
        req(0, 0, `ACT_OFF);
        settle(0);
        boots = 0;
        slow <= 1'b1;
        req(0, 0, `ACT_ON);
        settle(0);
        chk(boots[1:0], 2'h0);
    end
    endtask
    // Reset in mid-run with the host up; AC stays present with retention on
    task t_reset;
    begin
        slow     <= 1'b0;
        wake_lan <= 1'b0;
        req(0, 0, `ACT_ON);
        settle(1);
        @(posedge ref_clk) rst <= 1'b1;
        cyc(3);
        chk({host_pwr_en, busy, boot_start, wdog_run}, 4'h0);
        chk({sleep_state, fan_mode}, {`SLP_S5, `FAN_STOP});
        chk(button_protect, 1'b0);
        rst <= 1'b0;
        settle(1);
        cyc(2);
        chk(sleep_state, `SLP_S0);
    end
    endtask
    initial
    begin
        cyc(12);
        rst <= 1'b0;
        cyc(3);
        t_command;
        t_sources;
        t_sleep;
        t_reset;
        test_done;
    end
endmodule
